// ==== hdl/rcb_device.sv ====
// resampler control block: wishbone registers and output-stage datapath
// Behaviour
// RQ1 - output count code bits 0-1, 2 illegal
// RQ2 - filter count code bits 2-3, 2 illegal
// RQ3 - sync source resets all accumulators together
// RQ4 - multiply count 5 to 63, software keeps
// RQ5 - single output needs multiply count six
// RQ6 - symmetric filter unless asymmetric flag set
// RQ7 - per-output two-bit filter selection
// RQ8 - filter selection not above filter count
// RQ9 - shift result up 0 to 15 bits
// RQ10 - round to 12, 16, 20, 24 bits
// RQ11 - always 24-bit word, low bits kept
// RQ12 - tag mode replaces two low bits
// RQ13 - tag mode makes 24-bit rounding 22
// RQ14 - route each source to an output
// RQ15 - several sources may share one output
// RQ16 - merge bits A-B, B-C, C-D
// RQ17 - hold sample, channel_summing_control next one
// RQ18 - wrap merge bit kept zero
// RQ19 - ratio map changes wait for sync
// RQ20 - interleaved taps per filter count
`timescale 1ns/1ps
module rcb_device #(
    parameter int ACC_W = 40
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic [7:0] ratio_map_out,
    output logic [7:0] clock_divider_out,
    output logic asym_out,
    output logic [5:0] multiply_count_out,
    output logic [1:0] filter_phase_out,
    output logic [1:0] tap_stride_out,
    rcb_if.device link
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] chan_setup;
        logic [7:0] mult_setup;
        logic [7:0] filt_choice;
        logic [7:0] gain_round;
        logic [7:0] route_map;
        logic [7:0] sum_ctrl;
        logic [7:0] clk_div;
        logic [7:0] ratio_pend;
        logic [7:0] ratio_live;
        logic [3:0] illegal;
        logic ack;
        logic [31:0] rdata;
        logic [23:0] held;
        rcb_pkg::rcb_merge_t merge;
        logic [23:0] odata;
        logic [3:0] ovalid;
        logic [1:0] ofilt;
        logic [1:0] ochan;
        logic accrst;
    } rcb_state_t;
    rcb_state_t s_q;
    rcb_state_t s_d;
    logic hit;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic res_fire;
    logic ratio_fire;
    logic [1:0] src;
    logic found;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] shifted;
    logic [4:0] keep;
    logic [ACC_W-1:0] half;
    logic [ACC_W-1:0] rounded;
    logic [23:0] word;
    logic [23:0] sample;
    logic [1:0] tgt;

    always_comb begin
        s_d = s_q;
        idx = {2'h0, wb_adr_in[7:2]};
        hit = wb_cyc_in && wb_stb_in && !s_q.ack;
        wbyte = wb_dat_in[7:0];
        rbyte = 8'h00;
        res_fire = link.sync_pulse[s_q.chan_setup[rcb_pkg::POS_SYNC_SEL +: 3]]; // RQ3
        ratio_fire = link.sync_pulse[s_q.sum_ctrl[rcb_pkg::POS_SYNC_SEL +: 3]];
        src = 2'h0;
        found = 1'b0;
        sample = 24'h000000;
        acc = '0;
        shifted = '0;
        keep = 5'h00;
        half = '0;
        rounded = '0;
        word = 24'h000000;
        tgt = 2'h0;
        // ************************************************************
        // wishbone slave: one-cycle ack, unmapped reads zero
        // ************************************************************
        s_d.ack = hit;
        case (idx)
            rcb_pkg::IDX_CHANNEL_SETUP: rbyte = s_q.chan_setup;
            rcb_pkg::IDX_MULTIPLY_SETUP: rbyte = s_q.mult_setup;
            rcb_pkg::IDX_FILTER_CHOICE: rbyte = s_q.filt_choice;
            rcb_pkg::IDX_GAIN_ROUND: rbyte = s_q.gain_round;
            rcb_pkg::IDX_ROUTING_MAP: rbyte = s_q.route_map;
            rcb_pkg::IDX_SUMMING_CTRL: rbyte = s_q.sum_ctrl;
            rcb_pkg::IDX_CLOCK_DIVIDER: rbyte = s_q.clk_div;
            rcb_pkg::IDX_RATIO_MAP: rbyte = s_q.ratio_pend;
            rcb_pkg::IDX_STATUS: rbyte = {4'h0, s_q.illegal};
            default: rbyte = 8'h00;
        endcase
        if (hit && !wb_we_in) begin
            s_d.rdata = {24'h000000, rbyte};
        end
        // sticky error flags; set wins over clear-on-write
        if (hit && wb_we_in && wb_sel_in[0] && idx == rcb_pkg::IDX_STATUS) begin
            s_d.illegal = s_q.illegal & ~wbyte[3:0];
        end
        if (hit && wb_we_in && wb_sel_in[0]) begin
            case (idx)
                rcb_pkg::IDX_CHANNEL_SETUP: s_d.chan_setup = {1'b0, wbyte[6:0]};
                rcb_pkg::IDX_MULTIPLY_SETUP: s_d.mult_setup = {1'b0, wbyte[6:0]};
                rcb_pkg::IDX_FILTER_CHOICE: s_d.filt_choice = wbyte;
                rcb_pkg::IDX_GAIN_ROUND: s_d.gain_round = {1'b0, wbyte[6:0]};
                rcb_pkg::IDX_ROUTING_MAP: s_d.route_map = wbyte;
                rcb_pkg::IDX_SUMMING_CTRL: s_d.sum_ctrl = {1'b0, wbyte[6:0]};
                rcb_pkg::IDX_CLOCK_DIVIDER: s_d.clk_div = wbyte;
                rcb_pkg::IDX_RATIO_MAP: s_d.ratio_pend = wbyte;
                default: s_d.clk_div = s_q.clk_div;
            endcase
        end
        if (ratio_fire) begin
            s_d.ratio_live = s_q.ratio_pend; // RQ19
        end
        if (s_q.chan_setup[1:0] == rcb_pkg::CODE_ILLEGAL) s_d.illegal[0] = 1'b1; // RQ1
        if (s_q.chan_setup[3:2] == rcb_pkg::CODE_ILLEGAL) s_d.illegal[1] = 1'b1; // RQ2
        if (s_q.mult_setup[5:0] < rcb_pkg::MULT_MIN
            || (s_q.chan_setup[1:0] == 2'h0
            && s_q.mult_setup[5:0] < rcb_pkg::MULT_MIN_SINGLE)) begin
            s_d.illegal[2] = 1'b1; // RQ4 RQ5
        end
        if (s_q.sum_ctrl[3]) s_d.illegal[3] = 1'b1; // RQ18
        s_d.accrst = res_fire; // RQ3
        // ************************************************************
        // datapath: lowest-lettered valid source wins each cycle
        // ************************************************************
        for (int i = rcb_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (link.smp_valid[i]) begin
                src = 2'(i);
                found = 1'b1;
            end
        end
        sample = link.smp_data[src*24 +: 24];
        s_d.ovalid = 4'h0;
        if (res_fire) begin
            s_d.merge = rcb_pkg::RCB_MERGE_IDLE;
        end else if (found) begin
            // merge bit src means "add this source into the next one"
            if (src != 2'h3 && s_q.sum_ctrl[src]) begin // RQ16
                s_d.held = sample; // RQ17
                s_d.merge = rcb_pkg::RCB_MERGE_HELD;
            end else begin
                acc = ACC_W'($signed(sample));
                if (s_q.merge == rcb_pkg::RCB_MERGE_HELD) begin
                    acc = acc + ACC_W'($signed(s_q.held)); // RQ17
                end
                s_d.merge = rcb_pkg::RCB_MERGE_IDLE;
                shifted = acc << s_q.gain_round[rcb_pkg::POS_SHIFT +: 4]; // RQ9
                case (s_q.gain_round[rcb_pkg::POS_ROUND +: 2]) // RQ10
                    2'h0: keep = 5'd12;
                    2'h1: keep = 5'd16;
                    2'h2: keep = 5'd20;
                    default: keep = s_q.gain_round[rcb_pkg::POS_TAG] ? 5'd22 : 5'd24; // RQ13
                endcase
                half = (keep == 5'd24) ? '0 : (ACC_W'(1) << (5'd23 - keep));
                rounded = shifted + half;
                word = rounded[23:0]; // RQ11
                if (s_q.gain_round[rcb_pkg::POS_TAG]) begin
                    word[1:0] = link.tag_low[src*2 +: 2]; // RQ12
                end
                tgt = s_q.route_map[src*2 +: 2]; // RQ14 RQ15
                s_d.odata = word;
                s_d.ochan = tgt;
                s_d.ovalid[tgt] = 1'b1;
                s_d.ofilt = s_q.filt_choice[tgt*2 +: 2]; // RQ7
                if (s_d.ofilt > s_q.chan_setup[3:2]) begin
                    s_d.ofilt = 2'h0; // RQ8
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q <= '{chan_setup: rcb_pkg::RST_CHANNEL_SETUP,
                     mult_setup: rcb_pkg::RST_MULTIPLY_SETUP,
                     filt_choice: rcb_pkg::RST_FILTER_CHOICE,
                     gain_round: rcb_pkg::RST_GAIN_ROUND,
                     route_map: rcb_pkg::RST_ROUTING_MAP,
                     sum_ctrl: rcb_pkg::RST_SUMMING_CTRL,
                     clk_div: rcb_pkg::RST_CLOCK_DIVIDER,
                     ratio_pend: rcb_pkg::RST_RATIO_MAP,
                     ratio_live: rcb_pkg::RST_RATIO_MAP,
                     merge: rcb_pkg::RCB_MERGE_IDLE,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_ack_out = s_q.ack;
    assign wb_dat_out = s_q.rdata;
    assign ratio_map_out = s_q.ratio_live;
    assign clock_divider_out = s_q.clk_div;
    assign asym_out = s_q.mult_setup[rcb_pkg::POS_ASYM]; // RQ6
    assign multiply_count_out = s_q.mult_setup[5:0];
    assign filter_phase_out = s_q.ofilt; // RQ20
    assign tap_stride_out = s_q.chan_setup[3:2]; // RQ20
    assign link.out_data = s_q.odata;
    assign link.out_valid = s_q.ovalid;
    assign link.out_filter = s_q.ofilt;
    assign link.out_chan = s_q.ochan;
    assign link.acc_reset = s_q.accrst; // RQ3
endmodule : rcb_device

// ==== hdl/rcb_if.sv ====
// interface joining the control/datapath end and the channel-source end
`timescale 1ns/1ps
interface rcb_if;
    logic [3:0] smp_valid;
    logic [95:0] smp_data;
    logic [7:0] tag_low;
    logic [7:0] sync_pulse;
    logic [23:0] out_data;
    logic [3:0] out_valid;
    logic [1:0] out_filter;
    logic [1:0] out_chan;
    logic acc_reset;
    modport device (input smp_valid, smp_data, tag_low, sync_pulse,
                    output out_data, out_valid, out_filter, out_chan, acc_reset);
    modport source (output smp_valid, smp_data, tag_low, sync_pulse,
                    input out_data, out_valid, out_filter, out_chan, acc_reset);
endinterface : rcb_if

// ==== hdl/rcb_pkg.sv ====
// package: register map, field layout and constants of the resampler control block
package rcb_pkg;
    // ************************************************************
    // register indices; the bus byte address is 4*index
    // ************************************************************
    localparam logic [7:0] IDX_CHANNEL_SETUP = 8'h10;
    localparam logic [7:0] IDX_MULTIPLY_SETUP = 8'h11;
    localparam logic [7:0] IDX_FILTER_CHOICE = 8'h12;
    localparam logic [7:0] IDX_GAIN_ROUND = 8'h13;
    localparam logic [7:0] IDX_ROUTING_MAP = 8'h14;
    localparam logic [7:0] IDX_SUMMING_CTRL = 8'h15;
    localparam logic [7:0] IDX_CLOCK_DIVIDER = 8'h16;
    localparam logic [7:0] IDX_RATIO_MAP = 8'h17;
    localparam int NUM_REGS = 8;
    localparam logic [7:0] IDX_FIRST = 8'h10;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_CHANNEL_SETUP = 8'h23;
    localparam logic [7:0] RST_MULTIPLY_SETUP = 8'h0E;
    localparam logic [7:0] RST_FILTER_CHOICE = 8'h00;
    localparam logic [7:0] RST_GAIN_ROUND = 8'h34;
    localparam logic [7:0] RST_ROUTING_MAP = 8'hE4;
    localparam logic [7:0] RST_SUMMING_CTRL = 8'h70;
    localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
    localparam logic [7:0] RST_RATIO_MAP = 8'h00;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int POS_OUT_CHAN = 0;
    localparam int POS_FILT_CNT = 2;
    localparam int POS_SYNC_SEL = 4;
    localparam int POS_ASYM = 6;
    localparam int POS_SHIFT = 0;
    localparam int POS_ROUND = 4;
    localparam int POS_TAG = 6;
    localparam int DATA_W = 24;
    localparam int NUM_CH = 4;
    localparam logic [1:0] CODE_ILLEGAL = 2'h2;
    localparam logic [5:0] MULT_MIN = 6'h05;
    localparam logic [5:0] MULT_MIN_SINGLE = 6'h06;
    // status register of our own: sticky illegal-code flags
    localparam logic [7:0] IDX_STATUS = 8'h18;
    typedef enum logic [1:0] {
        RCB_MERGE_IDLE = 2'b00,
        RCB_MERGE_HELD = 2'b01
    } rcb_merge_t;
endpackage : rcb_pkg

// ==== hdl/rcb_source.sv ====
// channel-source end: four down-converter channel results presented to the resampler
`timescale 1ns/1ps
module rcb_source (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] chan_valid_in,
    input wire logic [95:0] chan_data_in,
    input wire logic [7:0] tag_low_in,
    input wire logic [7:0] sync_in,
    output logic [23:0] result_data_out,
    output logic [3:0] result_valid_out,
    output logic [1:0] result_chan_out,
    output logic acc_reset_out,
    rcb_if.source link
);
    // ************************************************************
    // registered presentation of samples and sync
    // ************************************************************
    typedef struct packed {
        logic [3:0] valid;
        logic [95:0] data;
        logic [7:0] tag;
        logic [7:0] sync;
        logic [23:0] rdata;
        logic [3:0] rvalid;
        logic [1:0] rchan;
        logic rst;
    } rcb_src_state_t;
    rcb_src_state_t s_q;
    rcb_src_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.valid = chan_valid_in;
        s_d.data = chan_data_in;
        s_d.tag = tag_low_in;
        s_d.sync = sync_in;
        s_d.rvalid = link.out_valid;
        s_d.rchan = link.out_chan;
        s_d.rst = link.acc_reset;
        if (link.out_valid != 4'h0) begin
            s_d.rdata = link.out_data;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.smp_valid = s_q.valid;
    assign link.smp_data = s_q.data;
    assign link.tag_low = s_q.tag;
    assign link.sync_pulse = s_q.sync;
    assign result_data_out = s_q.rdata;
    assign result_valid_out = s_q.rvalid;
    assign result_chan_out = s_q.rchan;
    assign acc_reset_out = s_q.rst;
endmodule : rcb_source

// ==== testbench/rcb_link_asserts.sv ====
// checker on the link between the two ends of the resampler control block
`timescale 1ns/1ps
module rcb_link_asserts (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] smp_valid,
    input wire logic [7:0] sync_pulse,
    input wire logic [23:0] out_data,
    input wire logic [3:0] out_valid,
    input wire logic [1:0] out_filter,
    input wire logic [1:0] out_chan,
    input wire logic acc_reset
);
    // ****
    // link rules
    // ****
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    AST_OUT_ONEHOT: assert property ($onehot0(out_valid))
        else $error("more than one output channel strobed");
    AST_OUT_CHAN: assert property (out_valid != 4'h0 |-> out_valid == (4'h1 << out_chan))
        else $error("strobe does not match output channel");
    AST_OUT_CAUSE: assert property (out_valid != 4'h0 |-> $past(smp_valid) != 4'h0)
        else $error("output without a sample");
    AST_IDLE_QUIET: assert property (smp_valid == 4'h0 |=> out_valid == 4'h0)
        else $error("output after idle cycle");
    AST_ACC_CAUSE: assert property (acc_reset |-> $past(sync_pulse) != 8'h00)
        else $error("accumulator reset without sync");
    AST_DATA_HOLD: assert property (out_valid == 4'h0 |-> $stable(out_data))
        else $error("output word changed without strobe");
    AST_FILT_HOLD: assert property (out_valid == 4'h0 |-> $stable(out_filter))
        else $error("filter changed without strobe");
    AST_CHAN_HOLD: assert property (out_valid == 4'h0 |-> $stable(out_chan))
        else $error("channel changed without strobe");
endmodule : rcb_link_asserts

// ==== testbench/resampler_control_block_tb.sv ====
// self-checking bench for both ends of the resampler control block
`timescale 1ns/1ps
module resampler_control_block_tb;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, asym, res_a;
    logic [7:0] adr = 8'h00, tl = 8'h00, sy = 8'h00, rmap, cdiv;
    logic [31:0] wdat = 32'h0, rdat, rd, rv, e, prev = 32'h0;
    logic [3:0] cv = 4'h0, res_v;
    logic [95:0] cd = 96'h0;
    logic [5:0] mcnt;
    logic [1:0] fph, tstr, res_c, lf;
    logic [23:0] res_d, held;
    logic [7:0] cfg_ch, cfg_fs, cfg_gr, cfg_rt, cfg_sm;
    logic [31:0] q[$];
    logic [7:0] rst_tab [8] = '{8'h23, 8'h0E, 8'h00, 8'h34, 8'hE4, 8'h70, 8'h00, 8'h00};
    logic [7:0] msk_tab [8] = '{8'h7F, 8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
    logic [1:0] fc_tab [3] = '{2'h0, 2'h1, 2'h3};
    logic [2:0] mg_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    integer seed = 32'hb951, n_fail = 0, comparisons = 0, n_acc = 0, n_sync = 0;
    rcb_if link_if();
    rcb_device rcb_device_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .ratio_map_out(rmap), .clock_divider_out(cdiv),
        .asym_out(asym), .multiply_count_out(mcnt), .filter_phase_out(fph),
        .tap_stride_out(tstr), .link(link_if));
    rcb_source rcb_source_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .chan_valid_in(cv),
        .chan_data_in(cd), .tag_low_in(tl), .sync_in(sy), .result_data_out(res_d),
        .result_valid_out(res_v), .result_chan_out(res_c), .acc_reset_out(res_a),
        .link(link_if));
    rcb_link_asserts rcb_link_asserts_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .smp_valid(link_if.smp_valid), .sync_pulse(link_if.sync_pulse),
        .out_data(link_if.out_data), .out_valid(link_if.out_valid),
        .out_filter(link_if.out_filter), .out_chan(link_if.out_chan),
        .acc_reset(link_if.acc_reset));
    // ****
    // tasks and model
    // ****
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_in);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task rd_chk(input logic [7:0] a, input logic [7:0] x);
        wb(1'b0, a, 8'h00);
        chk(rd, {24'h0, x});
    endtask : rd_chk
    function automatic logic [31:0] expect_out(int src, logic [23:0] v, logic [1:0] tg);
        logic [1:0] rt, fs;
        logic [23:0] x;
        int w;
        rt = cfg_rt[2*src +: 2];
        fs = cfg_fs[2*rt +: 2];
        w = (cfg_gr[5:4] == 2'h3) ? (cfg_gr[6] ? 22 : 24) : 12 + 4 * cfg_gr[5:4];
        x = v << cfg_gr[3:0];
        if (w < 24) x = x + (24'h1 << (23 - w));
        if (cfg_gr[6]) x[1:0] = tg;
        return {rt, (fs > cfg_ch[3:2]) ? 2'h0 : fs, 4'h1 << rt, x};
    endfunction : expect_out
    task send(int src);
        logic [23:0] s;
        logic [7:0] t;
        logic [31:0] x;
        s = $random(seed);
        t = $random(seed);
        @(posedge clk_in);
        cv <= 4'h1 << src;
        cd[24*src +: 24] <= s;
        tl <= t;
        if (src < 3 && cfg_sm[src]) held = held + s;
        else begin
            x = expect_out(src, held + s, t[2*src +: 2]);
            lf = x[29:28];
            q.push_back(x);
            held = 24'h0;
        end
    endtask : send
    task pulse(input logic [7:0] p);
        @(posedge clk_in);
        sy <= p;
        @(posedge clk_in);
        sy <= 8'h00;
        repeat (3) @(posedge clk_in);
    endtask : pulse
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // ****
    // clock, monitor, watchdog, sequence
    // ****
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        if (arst_n_in) begin
            chk({res_c, res_v, res_d, res_a}, prev);
            if (link_if.acc_reset === 1'b1) n_acc++;
            if (link_if.out_valid !== 4'h0) begin
                e = (q.size() > 0) ? q.pop_front() : 32'hFFFFFFFF;
                chk({link_if.out_chan, link_if.out_filter, link_if.out_valid, link_if.out_data}, e);
            end
        end
        prev = {link_if.out_chan, link_if.out_valid, link_if.out_data, link_if.acc_reset};
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        $display("watchdog expired");
        final_report;
    end
    initial begin
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) rd_chk(8'h40 + 8'(4 * i), rst_tab[i]);
        chk({asym, mcnt}, {1'b0, 6'h0E});
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, 8'h40 + 8'(4 * i), 8'hFF);
            rd_chk(8'h40 + 8'(4 * i), msk_tab[i]);
        end
        rd_chk(8'h70, 8'h00);
        chk({asym, mcnt, tstr, cdiv, rmap}, {1'b1, 6'h3F, 2'h3, 8'hFF, 8'h00});
        $display("test registers done");
        wb(1'b1, 8'h40, 8'h0A);
        wb(1'b1, 8'h44, 8'h04);
        rd_chk(8'h60, 8'h0F);
        wb(1'b1, 8'h40, 8'h20);
        wb(1'b1, 8'h44, 8'h05);
        wb(1'b1, 8'h54, 8'h70);
        wb(1'b1, 8'h60, 8'h0F);
        rd_chk(8'h60, 8'h04);
        wb(1'b1, 8'h44, 8'h0E);
        wb(1'b1, 8'h60, 8'h0F);
        rd_chk(8'h60, 8'h00);
        $display("test status done");
        wb(1'b1, 8'h5C, 8'hB4);
        pulse(8'h01);
        chk(rmap, 8'h00);
        pulse(8'h80);
        chk(rmap, 8'hB4);
        $display("test ratio map done");
        for (int n = 0; n < 8; n++) begin
            rv = $random(seed);
            cfg_ch = {4'h2, fc_tab[rv[1:0] % 3], 2'h3};
            cfg_fs = rv[15:8] & {4{cfg_ch[3:2]}};
            cfg_gr = {1'b0, rv[22:16]};
            cfg_rt = rv[31:24];
            cfg_sm = {4'h7, 1'b0, mg_tab[rv[6:4] % 5]};
            wb(1'b1, 8'h40, cfg_ch);
            wb(1'b1, 8'h48, cfg_fs);
            wb(1'b1, 8'h4C, cfg_gr);
            wb(1'b1, 8'h50, cfg_rt);
            wb(1'b1, 8'h54, cfg_sm);
            pulse(8'h04);
            held = 24'h0;
            n_sync++;
            for (int k = 0; k < 12; k++) send(k % 4);
            @(posedge clk_in);
            cv <= 4'h0;
            repeat (4) @(posedge clk_in);
            chk(q.size(), 0);
            chk({tstr, fph}, {cfg_ch[3:2], lf});
        end
        chk(n_acc, n_sync);
        $display("test datapath done");
        final_report;
    end
endmodule : resampler_control_block_tb
